/* File: include/cam_pix_pkg.sv */
// Constants and types shared by the CCD pixel control block
package cam_pix_pkg;
   // Register bus
   localparam int APB_AW = 8;
   localparam logic [7:0] OFS_GAIN = 8'h00;
   localparam logic [7:0] OFS_BRIGHT = 8'h04;
   localparam logic [7:0] OFS_BLUE = 8'h08;
   localparam logic [7:0] OFS_RED = 8'h0C;
   localparam logic [7:0] OFS_MODE = 8'h10;
   localparam logic [7:0] OFS_GREEN = 8'h14;
   localparam logic [7:0] OFS_GAIN_DB = 8'h18;
   // Field widths and reset values
   localparam int GAIN_W = 10;
   localparam int CODE_W = 8;
   localparam int RAW_W = 12;
   localparam int DB_W = 20;
   localparam logic [9:0] GAIN_RST = 10'h172;
   localparam logic [9:0] GAIN_UNITY = 10'h15E;
   localparam logic [9:0] GAIN_KNEE = 10'h200;
   localparam logic [7:0] BRIGHT_RST = 8'h10;
   localparam logic [7:0] BLUE_RST = 8'h70;
   localparam logic [7:0] RED_RST = 8'h40;
   localparam logic [7:0] GREEN_CODE = 8'h40;
   localparam logic [7:0] BAL_MIN = 8'h10;
   localparam int BAL_SHIFT = 6;
   // Brightness offset: 8-bit modes shift, 16-bit modes subtract
   localparam int BRIGHT_SHIFT8 = 4;
   localparam logic [7:0] BRIGHT_BASE16 = 8'h0F;
   localparam logic [7:0] MAX8 = 8'hFF;
   localparam logic [11:0] MAX12 = 12'hFFF;
   // Gain in units of 0.1 milli-dB
   localparam int DB_SEG_SHIFT = 4;
   localparam logic [8:0] DB_LIN_SLOPE = 9'h162;
   localparam logic [19:0] DB_LIN_OFS = 20'h19244;
   localparam logic [19:0] DB_LOG_TABLE [12] = '{
      20'h00000, 20'h01770, 20'h02FD0, 20'h04948, 20'h063EC, 20'h07FF8,
      20'h09D9E, 20'h0BD1A, 20'h0DED0, 20'h10324, 20'h12AAC, 20'h15612};
   // RGB to YUV weights, sum of Y weights is 256
   localparam logic [7:0] Y_R = 8'h4D;
   localparam logic [7:0] Y_G = 8'h96;
   localparam logic [7:0] Y_B = 8'h1D;
   localparam logic [7:0] U_R = 8'h2B;
   localparam logic [7:0] U_G = 8'h55;
   localparam logic [7:0] C_MAIN = 8'h80;
   localparam logic [7:0] V_G = 8'h6B;
   localparam logic [7:0] V_B = 8'h15;
   localparam int YUV_SHIFT = 8;
   typedef enum logic [2:0] {MONO8, RAW8, YUV422, MONO16, RAW16} mode_type;
endpackage : cam_pix_pkg

/* File: include/scale_if.sv */
// Carrier between the pipeline and one colour correction unit
`timescale 1ns/1ps
`default_nettype none
interface scale_if #(parameter int W = 8);
   logic [W-1:0] code;
   logic [W-1:0] value_in;
   logic [W-1:0] value_out;
   modport user (output code, output value_in, input value_out);
   modport unit (input code, input value_in, output value_out);
endinterface : scale_if
`default_nettype wire

/* File: rtl/balance_scale.sv */
// One colour correction: multiply by code, divide by 64, saturate
`timescale 1ns/1ps
`default_nettype none
module balance_scale (
   scale_if.unit port_s
);
   import cam_pix_pkg::*;
   logic [2*CODE_W-1:0] product;
   logic [2*CODE_W-BAL_SHIFT-1:0] shifted;

   // Factor is code/64, so code 64 is unity
   always_comb begin
      product = port_s.value_in * port_s.code;
      shifted = product[2*CODE_W-1:BAL_SHIFT];
      if (shifted > {{(CODE_W-BAL_SHIFT){1'b0}}, MAX8}) begin
         port_s.value_out = MAX8;
      end else begin
         port_s.value_out = shifted[CODE_W-1:0];
      end
   end
endmodule : balance_scale
`default_nettype wire

/* File: rtl/gain_db_calc.sv */
// Gain code to amplification in tenths of a milli-dB
`timescale 1ns/1ps
`default_nettype none
module gain_db_calc (
   input wire logic [cam_pix_pkg::GAIN_W-1:0] gain_code_value,
   output logic [cam_pix_pkg::DB_W-1:0] gain_db
);
   import cam_pix_pkg::*;
   logic [GAIN_W-1:0] rel;
   logic [3:0] idx;
   logic [3:0] frac;
   logic [DB_W-1:0] step;
   logic [DB_W+3:0] part;
   logic [DB_W+9:0] lin;

   // Log segment by table with linear interpolation; codes below unity clamp
   always_comb begin
      rel = (gain_code_value > GAIN_UNITY) ? gain_code_value - GAIN_UNITY : '0;
      idx = rel[7:4];
      frac = rel[3:0];
      step = DB_LOG_TABLE[idx+4'h1] - DB_LOG_TABLE[idx];
      part = step * frac;
      lin = gain_code_value * DB_LIN_SLOPE;
      if (gain_code_value >= GAIN_KNEE) begin
         gain_db = lin[DB_W-1:0] - DB_LIN_OFS;
      end else begin
         gain_db = DB_LOG_TABLE[idx] + part[DB_W+3:DB_SEG_SHIFT];
      end
   end
endmodule : gain_db_calc
`default_nettype wire

/* File: rtl/ccd_pixel_ctrl.sv */
// CCD gain, brightness offset and white balance with APB registers
//
// Function
// - Gain code 350 means 0 dB; higher codes amplify more.
// - Codes 350 to 511 follow the logarithmic dB formula.
// - Codes 512 to 1023 rise 0.0354 dB per step, minus 10.298.
// - At 0 dB dark pixels read 1, bright read full scale.
// - Brightness shifts level; gain scales amplitude only.
// - Brightness codes 0 to 255; above default raises, below lowers.
// - Brightness resets to 16.
// - 8-bit and YUV: code 16 gives offset 1, plus one per 16.
// - 16-bit modes: code 16 gives offset 1, plus one per step.
// - In YUV mode corrections apply to RGB before YUV.
// - Green correction fixed at 64, factor 1.0, not writable.
// - Blue factor is blue setting over 64.
// - Blue setting resets to 0x70.
// - Red factor is red setting over 64.
// - Red setting resets to 0x40.
// - Balance codes 0x10 to 0xFF accepted; software uses 0x40 up.
`timescale 1ns/1ps
`default_nettype none
module ccd_pixel_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cam_pix_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   input wire logic [cam_pix_pkg::RAW_W-1:0] in_raw,
   input wire logic [cam_pix_pkg::CODE_W-1:0] in_r,
   input wire logic [cam_pix_pkg::CODE_W-1:0] in_g,
   input wire logic [cam_pix_pkg::CODE_W-1:0] in_b,
   output logic [cam_pix_pkg::GAIN_W-1:0] variable_gain_stage,
   output logic out_valid,
   output logic [15:0] out_data
);
   import cam_pix_pkg::*;

   logic [GAIN_W-1:0] gain_code_value, next_gain;
   logic [CODE_W-1:0] brightness, next_brightness;
   logic [CODE_W-1:0] blue_balance_setting, next_blue;
   logic [CODE_W-1:0] red_balance_setting, next_red;
   mode_type mode, next_mode;
   logic [DB_W-1:0] gain_db, gain_db_now;
   logic next_pready, next_pslverr;
   logic [31:0] next_prdata;
   logic [GAIN_W-1:0] next_vgs;
   logic access, commit, mapped;

   scale_if #(.W(CODE_W)) blue_s ();
   scale_if #(.W(CODE_W)) red_s ();

   balance_scale blue_unit (.port_s(blue_s));
   balance_scale red_unit (.port_s(red_s));
   gain_db_calc db_unit (.gain_code_value(gain_code_value), .gain_db(gain_db_now));

   assign blue_s.code = blue_balance_setting;
   assign blue_s.value_in = in_b;
   assign red_s.code = red_balance_setting;
   assign red_s.value_in = in_r;

   // One wait state so read data can come from a flip-flop
   assign access = psel && penable;
   assign commit = access && pready && pwrite;

   // Bus answer and address decode
   always_comb begin
      next_pready = access && !pready;
      next_pslverr = 1'b0;
      next_prdata = '0;
      mapped = 1'b1;
      case (paddr)
         OFS_GAIN: next_prdata[GAIN_W-1:0] = gain_code_value;
         OFS_BRIGHT: next_prdata[CODE_W-1:0] = brightness;
         OFS_BLUE: next_prdata[CODE_W-1:0] = blue_balance_setting;
         OFS_RED: next_prdata[CODE_W-1:0] = red_balance_setting;
         OFS_MODE: next_prdata[2:0] = mode;
         OFS_GREEN: next_prdata[CODE_W-1:0] = GREEN_CODE;
         OFS_GAIN_DB: next_prdata[DB_W-1:0] = gain_db;
         default: mapped = 1'b0;
      endcase
      if (!next_pready) begin
         next_prdata = '0;
      end else begin
         next_pslverr = !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // Software settings; writes take effect only at the completing edge
   always_comb begin
      next_gain = gain_code_value;
      next_brightness = brightness;
      next_blue = blue_balance_setting;
      next_red = red_balance_setting;
      next_mode = mode;
      if (commit) begin
         case (paddr)
            OFS_GAIN: next_gain = pwdata[GAIN_W-1:0];
            OFS_BRIGHT: next_brightness = pwdata[CODE_W-1:0];
            OFS_BLUE: begin
               // Codes under the floor are lifted rather than refused
               next_blue = (pwdata[CODE_W-1:0] < BAL_MIN) ? BAL_MIN : pwdata[CODE_W-1:0];
            end
            OFS_RED: begin
               next_red = (pwdata[CODE_W-1:0] < BAL_MIN) ? BAL_MIN : pwdata[CODE_W-1:0];
            end
            OFS_MODE: begin
               // Undefined mode codes leave the mode unchanged
               if (pwdata[2:0] <= 3'(RAW16)) begin
                  next_mode = mode_type'(pwdata[2:0]);
               end
            end
            default: ;
         endcase
      end
      next_vgs = gain_code_value;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_code_value <= GAIN_RST;
         brightness <= BRIGHT_RST;
         blue_balance_setting <= BLUE_RST;
         red_balance_setting <= RED_RST;
         mode <= MONO8;
         variable_gain_stage <= GAIN_RST;
         gain_db <= '0;
      end else begin
         gain_code_value <= next_gain;
         brightness <= next_brightness;
         blue_balance_setting <= next_blue;
         red_balance_setting <= next_red;
         mode <= next_mode;
         variable_gain_stage <= next_vgs;
         gain_db <= gain_db_now;
      end
   end

   // Stage 1: corrected colour, raw sample, offset and mode travel together
   logic s1_valid, next_s1_valid;
   logic [CODE_W-1:0] s1_r, s1_g, s1_b, next_s1_r, next_s1_g, next_s1_b;
   logic [RAW_W-1:0] s1_raw, next_s1_raw;
   logic [CODE_W-1:0] s1_off, next_s1_off;
   mode_type s1_mode, next_s1_mode;

   always_comb begin
      next_s1_valid = in_valid;
      next_s1_raw = in_raw;
      next_s1_mode = mode;
      next_s1_g = in_g;
      next_s1_r = (mode == YUV422) ? red_s.value_out : in_r;
      next_s1_b = (mode == YUV422) ? blue_s.value_out : in_b;
      if (mode == MONO16 || mode == RAW16) begin
         // One count per code step above the base
         next_s1_off = (brightness > BRIGHT_BASE16) ? brightness - BRIGHT_BASE16 : '0;
      end else begin
         next_s1_off = brightness >> BRIGHT_SHIFT8;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_valid <= 1'b0;
         s1_r <= '0;
         s1_g <= '0;
         s1_b <= '0;
         s1_raw <= '0;
         s1_off <= '0;
         s1_mode <= MONO8;
      end else begin
         s1_valid <= next_s1_valid;
         s1_r <= next_s1_r;
         s1_g <= next_s1_g;
         s1_b <= next_s1_b;
         s1_raw <= next_s1_raw;
         s1_off <= next_s1_off;
         s1_mode <= next_s1_mode;
      end
   end

   // Stage 2: level offset or YUV, chroma alternating U then V
   logic next_out_valid, chroma_v, next_chroma_v;
   logic [15:0] next_out_data;
   logic [8:0] sum8;
   logic [12:0] sum12;
   logic [17:0] y_acc;
   logic signed [18:0] u_acc, v_acc;
   logic [7:0] y8, u8, v8;
   logic [8:0] ysum;

   always_comb begin
      next_out_valid = s1_valid;
      next_chroma_v = chroma_v;
      next_out_data = '0;
      sum8 = {1'b0, s1_raw[RAW_W-1:RAW_W-8]} + {1'b0, s1_off};
      sum12 = {1'b0, s1_raw} + {5'h00, s1_off};
      y_acc = s1_r * Y_R + s1_g * Y_G + s1_b * Y_B;
      // Main colour carries half weight; a full weight would overflow the chroma byte
      u_acc = $signed({3'b000, 16'(s1_b * C_MAIN)}) - $signed({3'b000, 16'(s1_r * U_R)})
         - $signed({3'b000, 16'(s1_g * U_G)});
      v_acc = $signed({3'b000, 16'(s1_r * C_MAIN)}) - $signed({3'b000, 16'(s1_g * V_G)})
         - $signed({3'b000, 16'(s1_b * V_B)});
      y8 = y_acc[15:8];
      // Brightness lifts luma only, chroma stays centred
      ysum = {1'b0, y8} + {1'b0, s1_off};
      u8 = 8'(u_acc >>> YUV_SHIFT) + C_MAIN;
      v8 = 8'(v_acc >>> YUV_SHIFT) + C_MAIN;
      if (s1_valid) begin
         case (s1_mode)
            MONO8, RAW8: begin
               // Offset is added after conversion, so amplitude is kept
               next_out_data[7:0] = sum8[8] ? MAX8 : sum8[7:0];
            end
            MONO16, RAW16: begin
               next_out_data[RAW_W-1:0] = sum12[RAW_W] ? MAX12 : sum12[RAW_W-1:0];
            end
            YUV422: begin
               next_out_data = {chroma_v ? v8 : u8, ysum[8] ? MAX8 : ysum[7:0]};
               next_chroma_v = !chroma_v;
            end
            default: next_out_data = '0;
         endcase
      end
      if (s1_mode != YUV422) begin
         next_chroma_v = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_data <= '0;
         chroma_v <= 1'b0;
      end else begin
         out_valid <= next_out_valid;
         out_data <= next_out_data;
         chroma_v <= next_chroma_v;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Grey level expected under unity balance: input plus brightness offset
   logic [8:0] grey_sum;
   logic [7:0] grey_exp;
   assign grey_sum = {1'b0, in_g} + {1'b0, brightness >> BRIGHT_SHIFT8};
   assign grey_exp = grey_sum[8] ? MAX8 : grey_sum[7:0];

   sequence bus_access_s;
      psel && penable && !pready;
   endsequence
   sequence mono8_dark_s;
      in_valid && mode == MONO8 && in_raw == '0 && brightness == BRIGHT_RST;
   endsequence

   apb_wait_one_a: assert property (bus_access_s |=> pready ##1 !pready)
      else $error("pready not one cycle after access");
   gain_write_a: assert property (commit && paddr == OFS_GAIN |=> ##1
      variable_gain_stage == $past(pwdata[GAIN_W-1:0], 2))
      else $error("gain code not forwarded");
   green_fixed_a: assert property (bus_access_s and (paddr == OFS_GREEN) |=>
      prdata == 32'(GREEN_CODE))
      else $error("green code read wrong");
   balance_floor_a: assert property (blue_balance_setting >= BAL_MIN
      && red_balance_setting >= BAL_MIN)
      else $error("balance code under floor");
   pipe_delay_a: assert property (in_valid |-> ##2 out_valid)
      else $error("pixel latency not two cycles");
   dark_level_a: assert property (mono8_dark_s |-> ##2 out_data == 16'h0001)
      else $error("dark pixel not one");
   step16_off_a: assert property (in_valid && mode == MONO16 && in_raw == '0
      && brightness == 8'h14 |-> ##2 out_data == 16'h0005)
      else $error("16-bit offset wrong");
   unity_grey_a: assert property (in_valid && mode == YUV422 && in_r == in_g
      && in_g == in_b && blue_balance_setting == GREEN_CODE
      && red_balance_setting == GREEN_CODE |-> ##2 out_data[7:0] == $past(grey_exp, 2))
      else $error("unity balance changed grey");
   unity_db_a: assert property (gain_code_value == GAIN_UNITY && $stable(gain_code_value)
      |=> gain_db == '0)
      else $error("unity gain not 0 dB");
endmodule : ccd_pixel_ctrl
`default_nettype wire

/* File: sim/sw_master.sv */
// Register bus master standing in for the processor software
`timescale 1ns/1ps
`default_nettype none
module sw_master (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [cam_pix_pkg::APB_AW-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import cam_pix_pkg::*;
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end
   // One transfer; gain values chosen by the caller stay 350 and up
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold until the answer; only the watchdog ends a hang
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines do not keep the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : sw_master
`default_nettype wire

/* File: sim/ccd_pixel_ctrl_tb.sv */
// Self-checking bench for the CCD pixel control block
`timescale 1ns/1ps
`default_nettype none
module ccd_pixel_ctrl_tb;
   import cam_pix_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_valid, out_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, x = 32'h0000_0060;
   logic [11:0] in_raw;
   logic [7:0] in_r, in_g, in_b;
   logic [9:0] variable_gain_stage;
   logic [15:0] out_data;
   logic [1:0] vh = 2'h0;
   int err_total = 0, check_count = 0, q[$];
   int gain = 370, bright = 16, blue = 112, red = 64, mode = 0, phase = 0;
   int bcodes[5] = '{0, 16, 20, 31, 255};
   ccd_pixel_ctrl i_ccd_pixel_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
      .in_raw(in_raw), .in_r(in_r), .in_g(in_g), .in_b(in_b),
      .variable_gain_stage(variable_gain_stage), .out_valid(out_valid),
      .out_data(out_data));
   sw_master i_sw_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : rnd
   // Write and mirror into the model; balance floor at 0x10
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      i_sw_master.xfer(1'b1, a, d, r, e);
      check(e, 0);
      case (a)
         8'h00: gain = d & 32'h3FF;
         8'h04: bright = d & 32'hFF;
         8'h08: blue = (d & 32'hFF) < 16 ? 16 : d & 32'hFF;
         8'h0C: red = (d & 32'hFF) < 16 ? 16 : d & 32'hFF;
         8'h10: if (d <= 4) mode = d;
         default: ;
      endcase
      if (mode != 2) phase = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic e;
      i_sw_master.xfer(1'b0, a, 32'h0, r, e);
      check(r, exp);
      check(e, ee);
   endtask : rd
   // Reference pixel: offset paths or balanced colour to YUV
   function automatic int ref_pix(int raw, int r, int g, int b);
      int v, y, c, rr, bb;
      if (mode == 2) begin
         rr = (r * red) >> 6;
         bb = (b * blue) >> 6;
         if (rr > 255) rr = 255;
         if (bb > 255) bb = 255;
         y = (77 * rr + 150 * g + 29 * bb) >>> 8;
         y = y + (bright >> 4);
         if (y > 255) y = 255;
         if (phase == 0) c = ((128 * bb - 43 * rr - 85 * g) >>> 8) + 128;
         else c = ((128 * rr - 107 * g - 21 * bb) >>> 8) + 128;
         phase ^= 1;
         return (c << 8) | y;
      end
      if (mode >= 3) begin
         v = raw + (bright > 15 ? bright - 15 : 0);
         return v > 4095 ? 4095 : v;
      end
      v = (raw >> 4) + (bright >> 4);
      return v > 255 ? 255 : v;
   endfunction : ref_pix
   // Back-to-back random pixels, then drain the pipe
   task automatic pix(input int n);
      int raw, r, g, b;
      for (int k = 0; k < n; k++) begin
         raw = rnd() & 32'hFFF;
         r = rnd() & 32'hFF;
         g = rnd() & 32'hFF;
         b = rnd() & 32'hFF;
         // First pixel dark and grey so the level assertions get exercised
         if (k == 0) begin
            raw = 0;
            g = r;
            b = r;
         end
         @(posedge pclk);
         in_valid <= 1'b1;
         in_raw <= raw[11:0];
         in_r <= r[7:0];
         in_g <= g[7:0];
         in_b <= b[7:0];
         q.push_back(ref_pix(raw, r, g, b));
      end
      @(posedge pclk);
      in_valid <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask : pix
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Output strobe two cycles after input, data against the model
   always @(posedge pclk) begin
      vh <= {vh[0], in_valid};
      if (presetn === 1'b1) check(out_valid, vh[1]);
      if (out_valid === 1'b1) begin
         if (q.size() == 0) check(1, 0);
         else check({16'h0, out_data}, q.pop_front());
      end
   end
   // Watchdog far beyond the expected run length
   initial begin
      #3_000_000;
      err_total++;
      wrap_up();
   end
   initial begin
      presetn = 1'b0;
      in_valid = 1'b0;
      in_raw = '0;
      in_r = '0;
      in_g = '0;
      in_b = '0;
      repeat (10) @(posedge pclk);
      check(variable_gain_stage, 370);
      presetn <= 1'b1;
      rd(8'h00, 370, 0);
      rd(8'h04, 16, 0);
      rd(8'h08, 32'h70, 0);
      rd(8'h0C, 32'h40, 0);
      rd(8'h10, 0, 0);
      rd(8'h20, 0, 1);
      wr(8'h14, 0);
      rd(8'h14, 32'h40, 0);
      wr(8'h00, 350);
      rd(8'h18, 0, 0);
      check(variable_gain_stage, gain);
      wr(8'h00, 512);
      rd(8'h18, 78268, 0);
      wr(8'h00, 1023);
      rd(8'h18, 259162, 0);
      wr(8'h00, 32'hFFFF_FD5E);
      rd(8'h00, 350, 0);
      wr(8'h08, 5);
      rd(8'h08, 32'h10, 0);
      wr(8'h0C, 32'h20);
      rd(8'h0C, 32'h20, 0);
      wr(8'h10, 7);
      rd(8'h10, 0, 0);
      // Every mode over boundary brightness codes
      for (int m = 0; m < 5; m++) begin
         wr(8'h10, m);
         foreach (bcodes[i]) begin
            wr(8'h04, bcodes[i]);
            if (m == 2) begin
               // Unity balance on the first pass keeps grey pixels grey
               wr(8'h08, i == 0 ? 64 : rnd() & 32'hFF);
               wr(8'h0C, i == 0 ? 64 : rnd() & 32'hFF);
            end
            pix(6);
         end
      end
      wrap_up();
   end
endmodule : ccd_pixel_ctrl_tb
`default_nettype wire
